// file: common/spc_pkg.sv
// Constants for the serial control port configuration register block
`default_nettype none
package spc_pkg;
    // Serial frame layout: 16-bit instruction, then data bytes
    localparam int ADDR_W = 13;
    localparam int INSTR_W = 16;
    localparam int BYTE_W = 8;
    localparam int INSTR_RW_BIT = 15;
    localparam int INSTR_LEN_HI = 14;
    localparam int INSTR_LEN_LO = 13;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // Register addresses
    localparam logic [12:0] CFG_ADDR = 13'h000;
    localparam logic [12:0] RBS_ADDR = 13'h004;
    localparam logic [12:0] PDS_ADDR = 13'h230;
    localparam logic [12:0] RSV_ADDR = 13'h231;
    localparam logic [12:0] UPD_ADDR = 13'h232;
    // Field positions
    localparam int CFG_OUT_PIN_SEL_BIT = 7;
    localparam int CFG_LSB_FIRST_BIT = 6;
    localparam int CFG_SOFT_RESET_BIT = 5;
    localparam int CFG_LONG_INSTR_BIT = 4;
    localparam int RBS_ACTIVE_BIT = 0;
    localparam int UPD_ALL_BIT = 0;
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam logic [7:0] RBS_RESET = 8'h00;
    localparam logic [7:0] PDS_RESET = 8'h00;
    localparam logic [7:0] RSV_VALUE = 8'h00;
    localparam logic [7:0] UPD_RESET = 8'h00;
    localparam logic [7:0] SOFT_MASK = 8'h20;
    // Port sequencer states
    typedef enum logic [1:0] {SPC_IDLE, SPC_INSTR, SPC_DATA, SPC_WAIT} spc_state_e;
endpackage : spc_pkg
`default_nettype wire

// file: rtl/spc_regs.sv
// Serial control port with configuration, readback select and update-all registers
`timescale 1ns/1ps
`default_nettype none
module spc_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_data_out_pin,
    output logic serial_data_out_pin_oe,
    output logic [7:0] power_down_sync_active
);
    // Pin synchronisers; stage 0 feeds only stage 1, stage 2 keeps the previous clock level
    logic [2:0] sclk_s_q;
    logic [1:0] cs_s_q;
    logic [1:0] sdio_s_q;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 2'h3;
            sdio_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk};
            cs_s_q <= {cs_s_q[0], cs_n};
            sdio_s_q <= {sdio_s_q[0], sdio_in};
        end
    end

    spc_pkg::spc_state_e state_q, state_d;
    logic [15:0] rx_q;
    logic [3:0] bit_cnt_q;
    logic [12:0] addr_q;
    logic rd_q;
    logic stream_q;
    logic [1:0] left_q;
    logic [7:0] tx_q;
    logic [7:0] cfg_q;
    logic [7:0] rbs_q;
    logic [7:0] pds_buf_q;
    logic [7:0] pds_act_q;
    logic [7:0] upd_q;

    // Edge and frame decode
    wire cs_active = ~cs_s_q[1];
    wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    wire out_pin_sel = cfg_q[spc_pkg::CFG_OUT_PIN_SEL_BIT];
    wire lsb_first = cfg_q[spc_pkg::CFG_LSB_FIRST_BIT];
    wire soft_rst = cfg_q[spc_pkg::CFG_SOFT_RESET_BIT];
    wire rb_active = rbs_q[spc_pkg::RBS_ACTIVE_BIT];
    wire [15:0] rx_next = {rx_q[14:0], sdio_s_q[1]};
    // LSB-first frames arrive as the bit-reverse of the MSB-first word
    // Reversal sits on its own nets since a stream operator may not feed a select directly
    wire [15:0] rx_rev = {<<{rx_next}};
    wire [7:0] byte_rev = {<<{rx_next[7:0]}};
    wire [15:0] instr_word = lsb_first ? rx_rev : rx_next;
    wire [7:0] byte_in = lsb_first ? byte_rev : rx_next[7:0];
    wire instr_done = (state_q == spc_pkg::SPC_INSTR) && sclk_rise && (bit_cnt_q == spc_pkg::INSTR_LAST);
    wire byte_done = (state_q == spc_pkg::SPC_DATA) && sclk_rise && (bit_cnt_q[2:0] == spc_pkg::BYTE_LAST);
    wire [12:0] instr_addr = instr_word[spc_pkg::INSTR_LEN_LO-1:0];
    wire [1:0] instr_len = instr_word[spc_pkg::INSTR_LEN_HI:spc_pkg::INSTR_LEN_LO];
    wire instr_rd = instr_word[spc_pkg::INSTR_RW_BIT];
    // Address walks down in MSB-first mode and up in LSB-first mode
    wire [12:0] step_addr = lsb_first ? addr_q + 13'h1 : addr_q - 13'h1;
    wire last_byte = ~stream_q && (left_q == 2'h0);
    wire wr_byte = byte_done && ~rd_q;

    // Readback mux; buffered registers show buffer or active copy
    function automatic logic [7:0] rd_mux(input logic [12:0] a, input logic [7:0] cfg, input logic [7:0] rbs,
                                          input logic [7:0] pds, input logic [7:0] upd);
        logic [7:0] r;
        r = spc_pkg::RSV_VALUE;
        if (a == spc_pkg::CFG_ADDR)
            r = cfg;
        else if (a == spc_pkg::RBS_ADDR)
            r = rbs;
        else if (a == spc_pkg::PDS_ADDR)
            r = pds;
        else if (a == spc_pkg::UPD_ADDR)
            r = upd;
        return r;
    endfunction : rd_mux
    wire [7:0] pds_view = rb_active ? pds_act_q : pds_buf_q;
    wire [12:0] load_addr = instr_done ? instr_addr : step_addr;
    wire [7:0] load_byte = rd_mux(load_addr, cfg_q, rbs_q, pds_view, upd_q);
    wire load_tx = (instr_done && instr_rd) || (byte_done && rd_q && ~last_byte);

    // Sequencer next state; chip select high always ends the frame
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            spc_pkg::SPC_IDLE: if (cs_active) state_d = spc_pkg::SPC_INSTR;
            spc_pkg::SPC_INSTR: if (instr_done) state_d = spc_pkg::SPC_DATA;
            spc_pkg::SPC_DATA: if (byte_done && last_byte) state_d = spc_pkg::SPC_WAIT;
            spc_pkg::SPC_WAIT: state_d = state_q;
        endcase
        if (!cs_active)
            state_d = spc_pkg::SPC_IDLE;
    end

    // Frame tracking and shift registers
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= spc_pkg::SPC_IDLE;
            rx_q <= 16'h0;
            bit_cnt_q <= 4'h0;
            addr_q <= 13'h0;
            rd_q <= 1'b0;
            stream_q <= 1'b0;
            left_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            if (!cs_active || state_q == spc_pkg::SPC_IDLE)
                bit_cnt_q <= 4'h0;
            else if (sclk_rise)
            begin
                rx_q <= rx_next;
                bit_cnt_q <= instr_done ? 4'h0 : bit_cnt_q + 4'h1;
            end
            if (instr_done)
            begin
                addr_q <= instr_addr;
                rd_q <= instr_rd;
                stream_q <= (instr_len == spc_pkg::LEN_STREAM);
                left_q <= instr_len;
            end
            else if (byte_done)
            begin
                addr_q <= step_addr;
                left_q <= left_q - 2'h1;
            end
        end
    end

    // Read shifter: loaded on the last sampling edge, shifted out on falling edges
    logic out_bit_q;
    logic rd_phase_q;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_q <= 8'h0;
            out_bit_q <= 1'b0;
            rd_phase_q <= 1'b0;
        end
        else
        begin
            rd_phase_q <= cs_active && rd_q && (state_q == spc_pkg::SPC_DATA);
            if (load_tx)
                tx_q <= load_byte;
            else if (sclk_fall && state_q == spc_pkg::SPC_DATA && rd_q)
            begin
                out_bit_q <= lsb_first ? tx_q[0] : tx_q[7];
                tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            end
        end
    end

    // Pin drivers; only one pin carries read data, the other floats
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            serial_data_out_pin <= 1'b0;
            serial_data_out_pin_oe <= 1'b0;
        end
        else
        begin
            sdio_out <= out_bit_q;
            sdio_oe <= rd_phase_q && ~out_pin_sel;
            serial_data_out_pin <= out_bit_q;
            serial_data_out_pin_oe <= rd_phase_q && out_pin_sel;
        end
    end

    // Register writes; soft reset holds everything at default but keeps its own bit
    wire wr_cfg = wr_byte && (addr_q == spc_pkg::CFG_ADDR);
    wire wr_rbs = wr_byte && (addr_q == spc_pkg::RBS_ADDR) && ~soft_rst;
    wire wr_pds = wr_byte && (addr_q == spc_pkg::PDS_ADDR) && ~soft_rst;
    wire wr_upd = wr_byte && (addr_q == spc_pkg::UPD_ADDR) && ~soft_rst;
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_q <= spc_pkg::CFG_RESET;
            rbs_q <= spc_pkg::RBS_RESET;
            pds_buf_q <= spc_pkg::PDS_RESET;
            pds_act_q <= spc_pkg::PDS_RESET;
            upd_q <= spc_pkg::UPD_RESET;
        end
        else
        begin
            if (wr_cfg)
                cfg_q <= byte_in;
            else if (soft_rst)
                cfg_q <= spc_pkg::CFG_RESET | spc_pkg::SOFT_MASK;
            if (soft_rst)
            begin
                rbs_q <= spc_pkg::RBS_RESET;
                pds_buf_q <= spc_pkg::PDS_RESET;
                pds_act_q <= spc_pkg::PDS_RESET;
                upd_q <= spc_pkg::UPD_RESET;
            end
            else
            begin
                if (wr_rbs)
                    rbs_q <= byte_in;
                if (wr_pds)
                    pds_buf_q <= byte_in;
                // Self-clearing transfer one cycle after the write lands
                if (upd_q[spc_pkg::UPD_ALL_BIT])
                    pds_act_q <= pds_buf_q;
                upd_q <= wr_upd ? (byte_in & 8'h01) : spc_pkg::UPD_RESET;
            end
        end
    end
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            power_down_sync_active <= spc_pkg::PDS_RESET;
        else
            power_down_sync_active <= pds_act_q;
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_out_pin_float: assert property (serial_data_out_pin_oe |-> $past(out_pin_sel))
        else $error("output pin driven in bidirectional mode");
    a_sdio_read_only: assert property (sdio_oe |-> !$past(out_pin_sel))
        else $error("data pin driven in unidirectional mode");
    a_addr_step_down: assert property (byte_done && !lsb_first && cs_active |=> addr_q == $past(addr_q) - 13'h1)
        else $error("address did not decrement");
    a_addr_step_up: assert property (byte_done && lsb_first && cs_active |=> addr_q == $past(addr_q) + 13'h1)
        else $error("address did not increment");
    a_soft_defaults: assert property (soft_rst |=> rbs_q == spc_pkg::RBS_RESET && pds_act_q == spc_pkg::PDS_RESET)
        else $error("soft reset did not restore defaults");
    a_soft_bit_kept: assert property (soft_rst && !wr_cfg |=> soft_rst)
        else $error("soft reset bit cleared itself");
    a_long_instr: assert property (state_q == spc_pkg::SPC_INSTR && sclk_rise && bit_cnt_q != spc_pkg::INSTR_LAST
                                   && cs_active |=> state_q == spc_pkg::SPC_INSTR)
        else $error("instruction ended before 16 bits");
    a_read_buffer: assert property (load_tx && !rb_active && load_addr == spc_pkg::PDS_ADDR
                                    |=> tx_q == $past(pds_buf_q))
        else $error("buffer readback wrong");
    a_read_active: assert property (load_tx && rb_active && load_addr == spc_pkg::PDS_ADDR
                                    |=> tx_q == $past(pds_act_q))
        else $error("active readback wrong");
    a_update_copy: assert property (wr_upd && byte_in[spc_pkg::UPD_ALL_BIT] ##1 !soft_rst
                                    |=> pds_act_q == $past(pds_buf_q) && upd_q == spc_pkg::UPD_RESET)
        else $error("update-all did not copy and clear");
    c_write_byte: cover property (wr_pds);
    c_read_stream: cover property (byte_done && rd_q && stream_q);
    c_update_all: cover property (upd_q[spc_pkg::UPD_ALL_BIT]);
endmodule : spc_regs
`default_nettype wire

// file: testbench/spc_host.sv
// Host model driving the serial control port
`timescale 1ns/1ps
`default_nettype none
module spc_host #(
    parameter int HALF = 6
) (
    input wire logic ref_clk,
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_data_out_pin,
    input wire logic serial_data_out_pin_oe
);
    logic drv_q = 1'b0;
    logic lsb = 1'b0; // Bit order the host assumes
    logic uni = 1'b0; // Pin direction the host assumes
    int pos;
    // Device drive wins on the shared pin
    assign sdio_in = sdio_oe ? sdio_out : drv_q;
    // Unknown unless only the selected pin is driven
    wire logic rd_bit = uni ? ((serial_data_out_pin_oe && !sdio_oe) ? serial_data_out_pin : 1'bx)
        : ((sdio_oe && !serial_data_out_pin_oe) ? sdio_out : 1'bx);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // Frame of instruction and n bytes; clock idles low between frames
    task automatic xfer(input logic rd, input logic [12:0] a, input int n, input logic [15:0] wd,
        output logic [15:0] r);
        logic [31:0] fr;
        fr = {rd, 2'(n - 1), a, wd};
        r = 16'h0000;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++)
        begin
            pos = lsb ? (i < 16 ? 16 + i : 8 * (1 - (i - 16) / 8) + (i - 16) % 8) : 31 - i;
            // Released line toggles so a stale value cannot pass
            drv_q <= (rd && i >= 16) ? ~drv_q : fr[pos];
            repeat (HALF - 1) @(posedge ref_clk);
            #1;
            if (pos < 16)
                r[pos] = rd_bit;
            @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk);
        cs_n <= 1'b1;
        repeat (HALF) @(posedge ref_clk);
    endtask : xfer
endmodule : spc_host
`default_nettype wire

// file: testbench/spc_regs_test.sv
// Self-checking testbench for the serial port configuration registers
`timescale 1ns/1ps
`default_nettype none
module spc_regs_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, serial_data_out_pin, serial_data_out_pin_oe;
    logic [7:0] power_down_sync_active;
    logic [31:0] seed = 32'h3edb6150;
    logic [7:0] v0, v1;
    logic [15:0] r;
    int error_cnt = 0;
    int checked = 0;
    always #4 ref_clk = ~ref_clk;
    spc_regs i_dut (.ref_clk(ref_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out_pin(serial_data_out_pin),
        .serial_data_out_pin_oe(serial_data_out_pin_oe), .power_down_sync_active(power_down_sync_active));
    spc_host i_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_data_out_pin(serial_data_out_pin),
        .serial_data_out_pin_oe(serial_data_out_pin_oe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Config byte whose low nibble mirrors the high nibble
    function automatic logic [7:0] cfg(input logic [3:0] h);
        return {h, h[0], h[1], h[2], h[3]};
    endfunction : cfg
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [12:0] a, input int n, input logic [15:0] d);
        logic [15:0] r;
        i_host.xfer(1'b0, a, n, d, r);
    endtask : wr
    task automatic rd1(input string what, input logic [12:0] a, input logic [7:0] exp);
        logic [15:0] r;
        i_host.xfer(1'b1, a, 1, 16'h0000, r);
        check(what, r[15:8], exp);
    endtask : rd1
    // Watchdog so a stuck frame still ends the run
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rd1("cfg", spc_pkg::CFG_ADDR, spc_pkg::CFG_RESET);
        rd1("rbs", spc_pkg::RBS_ADDR, 8'h00);
        rd1("upd", spc_pkg::UPD_ADDR, 8'h00);
        rd1("rsv", spc_pkg::RSV_ADDR, 8'h00);
        rd1("unmapped", 13'h100, 8'h00);
        // Buffer versus active bank, then update-all copy
        seed = xs(seed);
        v0 = seed[7:0];
        v1 = seed[15:8];
        wr(spc_pkg::PDS_ADDR, 1, {v0, 8'h00});
        rd1("pds buf", spc_pkg::PDS_ADDR, v0);
        check("pds act", power_down_sync_active, 8'h00);
        wr(spc_pkg::RBS_ADDR, 1, 16'h0100);
        rd1("pds act", spc_pkg::PDS_ADDR, 8'h00);
        wr(spc_pkg::UPD_ADDR, 1, 16'h0100);
        check("pds act", power_down_sync_active, v0);
        rd1("upd clr", spc_pkg::UPD_ADDR, 8'h00);
        rd1("pds act", spc_pkg::PDS_ADDR, v0);
        // Two bytes stepping down from the reserved address
        wr(spc_pkg::RBS_ADDR, 1, 16'h0000);
        wr(spc_pkg::RSV_ADDR, 2, {v0, v1});
        rd1("msb down", spc_pkg::PDS_ADDR, v1);
        // Two-byte read walks down from the reserved byte onto the buffer
        i_host.xfer(1'b1, spc_pkg::RSV_ADDR, 2, 16'h0000, r);
        check("rsv step", r[15:8], spc_pkg::RSV_VALUE);
        check("read down", r[7:0], v1);
        // Least significant bit first, stepping up onto the buffer
        wr(spc_pkg::CFG_ADDR, 1, {cfg(4'h5), 8'h00});
        i_host.lsb = 1'b1;
        wr(13'h22f, 2, {v1, v0});
        rd1("lsb up", spc_pkg::PDS_ADDR, v0);
        rd1("cfg lsb", spc_pkg::CFG_ADDR, cfg(4'h5));
        // Separate output pin carries read data
        wr(spc_pkg::CFG_ADDR, 1, {cfg(4'h9), 8'h00});
        i_host.uni = 1'b1;
        i_host.lsb = 1'b0;
        rd1("uni pds", spc_pkg::PDS_ADDR, v0);
        rd1("uni cfg", spc_pkg::CFG_ADDR, cfg(4'h9));
        // Soft reset restores defaults and keeps its own bit
        wr(spc_pkg::CFG_ADDR, 1, {cfg(4'hb), 8'h00});
        i_host.uni = 1'b0;
        rd1("cfg soft", spc_pkg::CFG_ADDR, spc_pkg::CFG_RESET | spc_pkg::SOFT_MASK);
        check("pds act", power_down_sync_active, 8'h00);
        wr(spc_pkg::PDS_ADDR, 1, {v1, 8'h00});
        rd1("pds held", spc_pkg::PDS_ADDR, 8'h00);
        wr(spc_pkg::CFG_ADDR, 1, {cfg(4'h1), 8'h00});
        rd1("cfg done", spc_pkg::CFG_ADDR, spc_pkg::CFG_RESET);
        wr(spc_pkg::PDS_ADDR, 1, {v1, 8'h00});
        rd1("pds after", spc_pkg::PDS_ADDR, v1);
        stop_test();
    end
endmodule : spc_regs_test
`default_nettype wire
